// [fbec_flash_ctrl.sv]
// Flash bank selection and erase command sequencer on the MPU special function register port
// Behaviour
// - Lower code half always maps to flash 0x0000-0x7FFF and a 2-bit bank code picks the upper window bank.
// - Writing 0x55 to the erase command register starts a page erase on the last written page number.
// - Writing 0xAA to the erase command register starts a mass erase only when the bulk erase arm is set.
// - Only the defined erase codes start an erase, and the command register is write-only and resets to zero.
// - The bulk erase arm resets to zero, disabling mass erase, and is write-only.
// - Writing one to bit 1 of the bulk erase arm register enables a following mass erase command.
// - No erase starts unless the 4-bit modify key holds 2.
`timescale 1ns/1ps
`default_nettype none
module fbec_flash_ctrl
	import fbec_pkg::*;
(
	input  wire logic                     clk_i,
	input  wire logic                     rst_b_i,
	// Special function register write/read port of the MPU core
	input  wire logic                     sfr_we_i,
	input  wire logic [7:0]               sfr_addr_i,
	input  wire logic [7:0]               sfr_wdata_i,
	output logic      [7:0]               sfr_rdata_o,
	// Modify key held elsewhere in the flash unit
	input  wire logic [FBEC_KEY_W-1:0]    modify_key_i,
	// Code fetch mapping
	input  wire logic [FBEC_CODE_AW-1:0]  code_addr_i,
	output logic      [FBEC_FLASH_AW-1:0] flash_addr_o,
	// Erase handshake with the flash macro
	input  wire logic                     erase_done_i,
	output logic                          page_erase_o,
	output logic                          mass_erase_o,
	output logic      [FBEC_PAGE_W-1:0]   erase_page_number_o,
	output logic                          erase_busy_o
);
	typedef struct packed {
		fbec_state_t            state;
		logic [FBEC_BANK_W-1:0] bank;
		logic                   arm;
		logic [FBEC_PAGE_W-1:0] page;
		logic [7:0]             cmd;
		logic                   page_go;
		logic                   mass_go;
		logic [FBEC_PAGE_W-1:0] erase_page;
	} fbec_regs_t;

	fbec_regs_t state_reg;
	fbec_regs_t state_next;

	logic wr_cmd;
	logic key_ok;

	// Decode of command register writes and unlock check
	assign wr_cmd = sfr_we_i && (sfr_addr_i == FBEC_ADDR_ERASE_COMMAND);
	assign key_ok = (modify_key_i == FBEC_KEY_UNLOCKED);

	// Register writes and erase sequencing
	always_comb begin
		state_next         = state_reg;
		state_next.page_go = 1'b0;
		state_next.mass_go = 1'b0;
		if (sfr_we_i && sfr_addr_i == FBEC_ADDR_BANK_SELECT) begin
			state_next.bank = sfr_wdata_i[FBEC_BANK_W-1:0];
		end
		if (sfr_we_i && sfr_addr_i == FBEC_ADDR_PAGE_NUMBER) begin
			state_next.page = sfr_wdata_i[FBEC_PAGE_LSB +: FBEC_PAGE_W];
		end
		if (sfr_we_i && sfr_addr_i == FBEC_ADDR_ARM_REG) begin
			state_next.arm = sfr_wdata_i[FBEC_ARM_BIT];
		end
		if (wr_cmd) begin
			state_next.cmd = sfr_wdata_i;
		end
		case (state_reg.state)
			FBEC_ST_IDLE: begin
				// Commands landing while busy are dropped; the macro cannot queue them
				if (wr_cmd && key_ok && sfr_wdata_i == FBEC_CMD_PAGE_ERASE) begin
					state_next.state      = FBEC_ST_PAGE;
					state_next.page_go    = 1'b1;
					state_next.erase_page = state_next.page;
				end else if (wr_cmd && key_ok && sfr_wdata_i == FBEC_CMD_MASS_ERASE
						&& state_reg.arm) begin
					state_next.state   = FBEC_ST_MASS;
					state_next.mass_go = 1'b1;
					state_next.arm     = 1'b0;
				end
				// Any other code falls through with no effect
			end
			FBEC_ST_PAGE, FBEC_ST_MASS: begin
				if (erase_done_i) begin
					state_next.state = FBEC_ST_IDLE;
				end
			end
			default: begin
				state_next.state = FBEC_ST_IDLE;
			end
		endcase
	end

	// State register with synchronous reset
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			state_reg.state      <= FBEC_ST_IDLE;
			state_reg.bank       <= FBEC_BANK_RST;
			state_reg.arm        <= 1'b0;
			state_reg.page       <= FBEC_PAGE_RST;
			state_reg.cmd        <= FBEC_ERASE_COMMAND_RST;
			state_reg.page_go    <= 1'b0;
			state_reg.mass_go    <= 1'b0;
			state_reg.erase_page <= FBEC_PAGE_RST;
		end else begin
			state_reg <= state_next;
		end
	end

	// Only the bank select reads back; write-only registers read zero
	always_comb begin
		sfr_rdata_o = 8'h00;
		if (sfr_addr_i == FBEC_ADDR_BANK_SELECT) begin
			sfr_rdata_o = {6'h00, state_reg.bank};
		end
	end

	assign page_erase_o        = state_reg.page_go;
	assign mass_erase_o        = state_reg.mass_go;
	assign erase_page_number_o = state_reg.erase_page;
	assign erase_busy_o        = (state_reg.state != FBEC_ST_IDLE);

	// Address mapping of fetches
	fbec_code_map u_map (
		.code_addr_i  (code_addr_i),
		.bank_i       (state_reg.bank),
		.flash_addr_o (flash_addr_o)
	);
endmodule : fbec_flash_ctrl
`default_nettype wire

// [fbec_pkg.sv]
// Package with register map, command codes and field layout of the flash bank and erase control
package fbec_pkg;
	// Special function register byte addresses
	localparam logic [7:0] FBEC_ADDR_ERASE_COMMAND   = 8'h94;
	localparam logic [7:0] FBEC_ADDR_ARM_REG         = 8'hB2;
	localparam logic [7:0] FBEC_ADDR_BANK_SELECT     = 8'hB6;
	localparam logic [7:0] FBEC_ADDR_PAGE_NUMBER     = 8'hB7;
	// Field positions
	localparam int         FBEC_ARM_BIT              = 1;
	localparam int         FBEC_PAGE_LSB             = 1;
	localparam int         FBEC_PAGE_W               = 7;
	localparam int         FBEC_BANK_W               = 2;
	localparam int         FBEC_KEY_W                = 4;
	// Reset values
	localparam logic [7:0] FBEC_ERASE_COMMAND_RST    = 8'h00;
	localparam logic [1:0] FBEC_BANK_RST             = 2'h1;
	localparam logic [6:0] FBEC_PAGE_RST             = 7'h00;
	// Command codes and unlock key
	localparam logic [7:0] FBEC_CMD_PAGE_ERASE       = 8'h55;
	localparam logic [7:0] FBEC_CMD_MASS_ERASE       = 8'hAA;
	localparam logic [3:0] FBEC_KEY_UNLOCKED         = 4'h2;
	// Code space geometry
	localparam int         FBEC_CODE_AW              = 16;
	localparam int         FBEC_FLASH_AW             = 17;
	localparam int         FBEC_WINDOW_AW            = 15;
	// Controller sequencer states, one-hot
	typedef enum logic [2:0] {
		FBEC_ST_IDLE = 3'b001,
		FBEC_ST_PAGE = 3'b010,
		FBEC_ST_MASS = 3'b100
	} fbec_state_t;
endpackage : fbec_pkg

// [fbec_code_map.sv]
// Code space to flash address mapping for the banked upper window
`timescale 1ns/1ps
`default_nettype none
module fbec_code_map
	import fbec_pkg::*;
(
	input  wire logic [FBEC_CODE_AW-1:0]  code_addr_i,
	input  wire logic [FBEC_BANK_W-1:0]   bank_i,
	output logic      [FBEC_FLASH_AW-1:0] flash_addr_o
);
	// Lower half is fixed to flash 0x0000-0x7FFF; upper half takes the bank number
	always_comb begin
		if (!code_addr_i[FBEC_CODE_AW-1]) begin
			flash_addr_o = {2'h0, code_addr_i[FBEC_WINDOW_AW-1:0]};
		end else begin
			flash_addr_o = {bank_i, code_addr_i[FBEC_WINDOW_AW-1:0]};
		end
	end
endmodule : fbec_code_map
`default_nettype wire

// [fbec_flash_ctrl_checker.sv]
// Checker of bank mapping and erase start for the flash control block
`timescale 1ns/1ps
`default_nettype none
module fbec_flash_ctrl_checker
	import fbec_pkg::*;
(
	input wire logic        clk_i, rst_b_i, sfr_we_i, erase_done_i,
	input wire logic        page_erase_o, mass_erase_o, erase_busy_o,
	input wire logic [7:0]  sfr_addr_i, sfr_wdata_i, sfr_rdata_o,
	input wire logic [3:0]  modify_key_i,
	input wire logic [15:0] code_addr_i,
	input wire logic [16:0] flash_addr_o,
	input wire logic [6:0]  erase_page_number_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	logic arm_reg;
	// Shadow of the arm bit, dropped once a mass erase has been used
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) arm_reg <= 1'b0;
		else if (mass_erase_o) arm_reg <= 1'b0;
		else if (sfr_we_i && sfr_addr_i == FBEC_ADDR_ARM_REG) arm_reg <= sfr_wdata_i[FBEC_ARM_BIT];
	end
	// Accepted command write while unlocked and idle
	sequence s_cmd(logic [7:0] c);
		sfr_we_i && sfr_addr_i == FBEC_ADDR_ERASE_COMMAND && sfr_wdata_i == c
			&& modify_key_i == FBEC_KEY_UNLOCKED && !erase_busy_o;
	endsequence
	a_lower_map: assert property (!code_addr_i[15] |-> flash_addr_o == {1'b0, code_addr_i})
		else $error("lower code half mapped wrong");
	a_upper_map: assert property (code_addr_i[15] && sfr_addr_i == FBEC_ADDR_BANK_SELECT
		|-> flash_addr_o == {sfr_rdata_o[1:0], code_addr_i[14:0]}) else $error("upper bank wrong");
	a_page_go: assert property (s_cmd(FBEC_CMD_PAGE_ERASE) |=> page_erase_o && erase_busy_o)
		else $error("page erase not started");
	a_mass_arm: assert property (s_cmd(FBEC_CMD_MASS_ERASE) |=> mass_erase_o == $past(arm_reg))
		else $error("mass erase start differs from arm");
	a_key_lock: assert property (modify_key_i != FBEC_KEY_UNLOCKED |=> !page_erase_o && !mass_erase_o)
		else $error("erase started while locked");
	a_undef_code: assert property (sfr_we_i && sfr_addr_i == FBEC_ADDR_ERASE_COMMAND
		&& sfr_wdata_i != FBEC_CMD_PAGE_ERASE && sfr_wdata_i != FBEC_CMD_MASS_ERASE
		|=> !page_erase_o && !mass_erase_o) else $error("undefined code started erase");
	a_pulse_cause: assert property (page_erase_o |-> $past(sfr_we_i) && $past(sfr_wdata_i) == FBEC_CMD_PAGE_ERASE)
		else $error("page erase without command");
	// Erase completion seen while busy must free the sequencer on the next edge
	a_busy_drop: assert property (erase_busy_o && erase_done_i |=> !erase_busy_o)
		else $error("busy held after erase done");
	// Start pulses only ever last a single cycle
	a_pulse_len: assert property (page_erase_o || mass_erase_o |=> !page_erase_o && !mass_erase_o)
		else $error("erase start pulse too long");
	a_write_only: assert property (sfr_addr_i == FBEC_ADDR_ERASE_COMMAND || sfr_addr_i == FBEC_ADDR_ARM_REG
		|-> sfr_rdata_o == 8'h00) else $error("write-only register readable");
endmodule : fbec_flash_ctrl_checker
bind fbec_flash_ctrl fbec_flash_ctrl_checker u_chk (.clk_i(clk_i), .rst_b_i(rst_b_i),
	.sfr_we_i(sfr_we_i), .erase_done_i(erase_done_i), .page_erase_o(page_erase_o),
	.mass_erase_o(mass_erase_o), .erase_busy_o(erase_busy_o), .sfr_addr_i(sfr_addr_i),
	.sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o), .modify_key_i(modify_key_i),
	.code_addr_i(code_addr_i), .flash_addr_o(flash_addr_o), .erase_page_number_o(erase_page_number_o));
`default_nettype wire

// [test_flash_bank_and_erase_control.sv]
// Directed testbench of the flash bank and erase control block
`timescale 1ns/1ps
`default_nettype none
module test_flash_bank_and_erase_control
	import fbec_pkg::*;
;
	logic clk_i = 0, rst_b_i = 0, we = 0, done = 0, pg, ms, busy;
	logic [7:0] addr = 0, wd = 0, rd;
	logic [3:0] key = 4'h2;
	logic [15:0] ca = 0;
	logic [16:0] fa;
	logic [6:0] pn;
	int miscompares = 0, samples_checked = 0;
	// Byte patterns next to the two defined codes plus 0x00 and 0xFF, the likeliest decode slips
	logic [7:0] undef_codes [6] = '{8'h00, 8'h54, 8'h56, 8'hA9, 8'hAB, 8'hFF};
	fbec_flash_ctrl dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .sfr_we_i(we), .sfr_addr_i(addr),
		.sfr_wdata_i(wd), .sfr_rdata_o(rd), .modify_key_i(key), .code_addr_i(ca),
		.flash_addr_o(fa), .erase_done_i(done), .page_erase_o(pg), .mass_erase_o(ms),
		.erase_page_number_o(pn), .erase_busy_o(busy));
	always #10 clk_i = ~clk_i;
	// One write strobe per call, so returning lands in the cycle of any start pulse
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_i); we = 1; addr = a; wd = d;
		@(negedge clk_i); we = 0; addr = FBEC_ADDR_BANK_SELECT;
	endtask : wr
	task chk(input logic [16:0] g, input logic [16:0] e);
		samples_checked++;
		if (g !== e) begin miscompares++; $display("[ERR] %0t got %h exp %h", $time, g, e); end
	endtask : chk
	// Erase completion, then room for busy to fall
	task finish_erase();
		@(negedge clk_i); done = 1;
		@(negedge clk_i); done = 0;
		@(negedge clk_i); chk(busy, 0);
	endtask : finish_erase
	task results();
		$display("Counts: %0d checked, %0d mismatched", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : results
	initial begin
		#100000; miscompares++; results();
	end
	initial begin
		repeat (20) @(negedge clk_i);
		rst_b_i = 1;
		@(negedge clk_i); addr = FBEC_ADDR_BANK_SELECT; #1 chk(rd, 8'h01);
		addr = FBEC_ADDR_ERASE_COMMAND; #1 chk(rd, 8'h00);
		addr = FBEC_ADDR_ARM_REG; #1 chk(rd, 8'h00);
		wr(FBEC_ADDR_ERASE_COMMAND, 8'hAA); chk(ms, 0);
		$display("Test reset done");
		for (int b = 0; b < 4; b++) begin
			wr(FBEC_ADDR_BANK_SELECT, 8'(b));
			ca = 16'h1234; #1 chk(fa, 17'h01234);
			ca = 16'hF00D; #1 chk(fa, {2'(b), 15'h700D});
		end
		$display("Test bank map done");
		wr(FBEC_ADDR_PAGE_NUMBER, 8'h7E); wr(FBEC_ADDR_ERASE_COMMAND, 8'h55);
		chk(pg, 1); chk(pn, 7'h3F); chk(busy, 1);
		wr(FBEC_ADDR_PAGE_NUMBER, 8'h0A); chk(pn, 7'h3F); finish_erase();
		wr(FBEC_ADDR_ERASE_COMMAND, 8'h55); chk(pn, 7'h05); finish_erase();
		$display("Test page erase done");
		wr(FBEC_ADDR_ARM_REG, 8'h02); wr(FBEC_ADDR_ERASE_COMMAND, 8'hAA); chk(ms, 1);
		finish_erase();
		wr(FBEC_ADDR_ERASE_COMMAND, 8'hAA); chk(ms, 0); chk(busy, 0);
		$display("Test mass erase done");
		key = 4'h3; wr(FBEC_ADDR_ARM_REG, 8'h02);
		wr(FBEC_ADDR_ERASE_COMMAND, 8'h55); chk(pg, 0);
		wr(FBEC_ADDR_ERASE_COMMAND, 8'hAA); chk(ms, 0); key = 4'h2;
		foreach (undef_codes[i]) begin
			wr(FBEC_ADDR_ERASE_COMMAND, undef_codes[i]); chk({pg, ms, busy}, 0);
		end
		for (int c = 0; c < 256; c += 51) begin
			wr(FBEC_ADDR_ERASE_COMMAND, 8'(c) ^ 8'h01); chk({pg, ms, busy}, 0);
		end
		$display("Test refusals done");
		results();
	end
endmodule : test_flash_bank_and_erase_control
`default_nettype wire
